// File: tb.sv
`timescale 1ns/1ps
module tb
  import tlbmp_pkg::*;
();
  logic        aclk;
  logic        aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          err_total;
  int          checked;
  int          cycles;
  typedef struct packed {
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [7:0]  ra;
    logic [31:0] ex;
  } tlbmp_row_s;
  // Write one place, then read where its effect must show
  localparam tlbmp_row_s ROWS [13] = '{
    '{OFF_TB, 32'h1111_0000, OFF_T_TB_I, 32'h1111_0000},
    '{OFF_T_TB_D, 32'h2222_0000, OFF_TB, 32'h2222_0000},
    '{OFF_T_TB_I, 32'h3333_0000, OFF_TB, 32'h2222_0000},
    '{OFF_DOM, 32'h5555_aaaa, OFF_T_DOM_I, 32'h5555_aaaa},
    '{OFF_T_DOM_D, 32'h0000_ffff, OFF_DOM, 32'h0000_ffff},
    '{OFF_T_DOM_I, 32'h1234_5678, OFF_DOM, 32'h0000_ffff},
    '{OFF_FS_D, 32'h0000_00f5, OFF_FS_D, 32'h0000_00f5},
    '{OFF_FS_I, 32'h0000_000d, OFF_T_FS_I, 32'h0000_000d},
    '{OFF_T_FS_I, 32'h0000_000a, OFF_FS_I, 32'h0000_000a},
    '{OFF_FA_D, 32'hcafe_0000, OFF_FA_D, 32'hcafe_0000},
    '{OFF_FA_I, 32'hbeef_0000, OFF_FA_I, 32'hbeef_0000},
    '{OFF_LOCK_D, 32'h1470_0001, OFF_LOCK_D, 32'h1470_0001},
    '{OFF_LOCK_I, 32'h0830_0000, OFF_LOCK_I, 32'h0830_0000}};

  tlbmp_port tlbmp_port_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  tlbmp_axi_master tlbmp_axi_master_inst (
    .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  // 100 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Response code and data compared as one word
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] dv);
    logic [1:0] rr;
    tlbmp_axi_master_inst.wr(a, dv, rr);
    chk({rr, 32'h0}, {RESP_OKAY, 32'h0});
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] dd;
    logic [1:0]  rr;
    tlbmp_axi_master_inst.rd(a, dd, rr);
    chk({rr, dd}, {RESP_OKAY, e});
  endtask

  // A hang is cut short well beyond the few hundred cycles the run needs
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      give_verdict();
    end
  end

  initial
  begin
    aresetn   = 1'b0;
    err_total = 0;
    checked   = 0;
    cycles    = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rc(OFF_TB, REG_RST);
    rc(OFF_LOCK_D, REG_RST);
    $display("test reset done");
    foreach (ROWS[i])
    begin
      w(ROWS[i].wa, ROWS[i].wd);
      rc(ROWS[i].ra, ROWS[i].ex);
    end
    $display("test registers done");
    // Index 0 gets a 1KB entry, domain 1, AP 1000 on both sides
    w(OFF_LOCK_D, 32'h0);
    w(OFF_LOCK_I, 32'h0);
    w(OFF_TAG_WR_B, 32'h002a_f020);
    w(OFF_PRT_WR_B, 32'h0000_0018);
    rc(OFF_LOCK_D, 32'h0010_0000);
    rc(OFF_LOCK_I, 32'h0010_0000);
    w(OFF_LOCK_D, 32'h0);
    w(OFF_TAG_RD_D, 32'h0);
    rc(OFF_RES_D, 32'h002a_f020);
    w(OFF_PRT_RD_D, 32'h0);
    rc(OFF_LOCK_D, 32'h0);
    w(OFF_FS_D, 32'h0);
    rc(OFF_RES_D, 32'h0000_0018);
    rc(OFF_RES_I, 32'h0);
    w(OFF_TEST_STAT, 32'h0000_0008);
    w(OFF_TAG_RD_D, 32'h0);
    rc(OFF_LOCK_D, 32'h0010_0000);
    // Physical tag follows the last tag access, not the live pointer
    w(OFF_PT_WR_D, 32'h1234_5670);
    w(OFF_LOCK_D, 32'h0);
    w(OFF_PT_RD_D, 32'h0);
    rc(OFF_RES_D, 32'h1234_5670);
    w(OFF_TAG_RD_D, 32'h0);
    w(OFF_PT_RD_D, 32'h0);
    rc(OFF_RES_D, 32'h1234_5670);
    $display("test arrays done");
    w(OFF_TEST_STAT, 32'h0);
    w(OFF_T_DOM_D, 32'h0000_0004);
    w(OFF_MATCH_D, 32'h002a_f000);
    rc(OFF_RES_D, 32'h0000_0018);
    w(OFF_MATCH_D, 32'hfff0_0000);
    rc(OFF_RES_D, 32'h0040_0000);
    w(OFF_T_DOM_D, 32'h0);
    w(OFF_MATCH_D, 32'h002a_f000);
    rc(OFF_RES_D, 32'h0080_0018);
    // Client domain with AP 0001 gives a protection fault
    w(OFF_T_DOM_D, 32'h0000_0004);
    w(OFF_LOCK_D, 32'h0);
    w(OFF_PRT_WR_D, 32'h0000_0011);
    w(OFF_MATCH_D, 32'h002a_f000);
    rc(OFF_RES_D, 32'h0100_0011);
    w(OFF_INV_ONE_D, 32'h002a_f000);
    w(OFF_MATCH_D, 32'h002a_f000);
    rc(OFF_RES_D, 32'h0040_0000);
    w(OFF_MATCH_I, 32'h002a_f000);
    rc(OFF_RES_I, 32'h0000_0018);
    w(OFF_INV_I, 32'h0);
    w(OFF_MATCH_I, 32'h002a_f000);
    rc(OFF_RES_I, 32'h0040_0000);
    $display("test match done");
    // Write-only, read-only and unmapped places are refused
    tlbmp_axi_master_inst.rd(OFF_INV_ALL, d, r);
    chk({r, d}, {RESP_SLVERR, 32'h0});
    tlbmp_axi_master_inst.wr(OFF_RES_I, 32'h1, r);
    chk({r, 32'h0}, {RESP_SLVERR, 32'h0});
    rc(OFF_RES_I, 32'h0040_0000);
    tlbmp_axi_master_inst.rd(8'hfc, d, r);
    chk({r, d}, {RESP_SLVERR, 32'h0});
    $display("test refusals done");
    // Preserved entries outlive a whole invalidate; a data-side one spares the other side
    w(OFF_LOCK_D, 32'h0);
    w(OFF_TAG_WR_D, 32'h002a_f030);
    w(OFF_TAG_WR_I, 32'h002a_f020);
    w(OFF_INV_ALL, 32'h0);
    w(OFF_MATCH_D, 32'h002a_f000);
    rc(OFF_RES_D, 32'h0100_0011);
    w(OFF_MATCH_I, 32'h002a_f000);
    rc(OFF_RES_I, 32'h0040_0000);
    w(OFF_TAG_WR_I, 32'h002a_f020);
    w(OFF_INV_D, 32'h0);
    w(OFF_MATCH_I, 32'h002a_f000);
    rc(OFF_RES_I, 32'h0080_0000);
    $display("test invalidate done");
    // Reset in mid-run clears latches and registers alike
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc(OFF_TB, REG_RST);
    rc(OFF_RES_I, REG_RST);
    rc(OFF_LOCK_I, REG_RST);
    $display("test reset again done");
    give_verdict();
  end
endmodule

// File: tlbmp_axi_master.sv
`timescale 1ns/1ps
// Core-side model: one write and one read at a time, the same port for debug hosts
module tlbmp_axi_master
  import tlbmp_pkg::*;
(
  input  wire logic        aclk,
  output      logic [7:0]  s_axi_awaddr,
  output      logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output      logic [31:0] s_axi_wdata,
  output      logic [3:0]  s_axi_wstrb,
  output      logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output      logic        s_axi_bready,
  output      logic [7:0]  s_axi_araddr,
  output      logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output      logic        s_axi_rready
);
  // Idle at time zero
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // Released payloads show the inverse so a stale value is never mistaken for live
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1)
      begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~a;
      end
      if (!w_ok && s_axi_wready === 1'b1)
      begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~d;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // Read results are fetched only through this read
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr  <= ~a;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// File: tlbmp_pkg.sv
package tlbmp_pkg;

  // Array geometry
  localparam int TLB_ENTRIES = 64;
  localparam int IDX_W       = 6;
  localparam int SIDE_D      = 0;
  localparam int SIDE_I      = 1;

  // Register byte offsets
  localparam logic [7:0] OFF_TB        = 8'h00;
  localparam logic [7:0] OFF_DOM       = 8'h04;
  localparam logic [7:0] OFF_FS_D      = 8'h08;
  localparam logic [7:0] OFF_FS_I      = 8'h0c;
  localparam logic [7:0] OFF_FA_D      = 8'h10;
  localparam logic [7:0] OFF_FA_I      = 8'h14;
  localparam logic [7:0] OFF_INV_ALL   = 8'h18;
  localparam logic [7:0] OFF_INV_I     = 8'h1c;
  localparam logic [7:0] OFF_INV_D     = 8'h20;
  localparam logic [7:0] OFF_INV_ONE_I = 8'h24;
  localparam logic [7:0] OFF_INV_ONE_D = 8'h28;
  localparam logic [7:0] OFF_LOCK_D    = 8'h2c;
  localparam logic [7:0] OFF_LOCK_I    = 8'h30;
  localparam logic [7:0] OFF_T_TB_I    = 8'h34;
  localparam logic [7:0] OFF_T_TB_D    = 8'h38;
  localparam logic [7:0] OFF_T_DOM_I   = 8'h3c;
  localparam logic [7:0] OFF_T_DOM_D   = 8'h40;
  localparam logic [7:0] OFF_T_FS_I    = 8'h44;
  localparam logic [7:0] OFF_TEST_STAT = 8'h48;
  localparam logic [7:0] OFF_TAG_RD_D  = 8'h50;
  localparam logic [7:0] OFF_TAG_RD_I  = 8'h54;
  localparam logic [7:0] OFF_TAG_WR_D  = 8'h58;
  localparam logic [7:0] OFF_TAG_WR_I  = 8'h5c;
  localparam logic [7:0] OFF_TAG_WR_B  = 8'h60;
  localparam logic [7:0] OFF_PRT_RD_D  = 8'h64;
  localparam logic [7:0] OFF_PRT_RD_I  = 8'h68;
  localparam logic [7:0] OFF_PRT_WR_D  = 8'h6c;
  localparam logic [7:0] OFF_PRT_WR_I  = 8'h70;
  localparam logic [7:0] OFF_PRT_WR_B  = 8'h74;
  localparam logic [7:0] OFF_PT_RD_D   = 8'h78;
  localparam logic [7:0] OFF_PT_RD_I   = 8'h7c;
  localparam logic [7:0] OFF_PT_WR_D   = 8'h80;
  localparam logic [7:0] OFF_PT_WR_I   = 8'h84;
  localparam logic [7:0] OFF_PT_WR_B   = 8'h88;
  localparam logic [7:0] OFF_MATCH_D   = 8'h8c;
  localparam logic [7:0] OFF_MATCH_I   = 8'h90;
  localparam logic [7:0] OFF_RES_D     = 8'h94;
  localparam logic [7:0] OFF_RES_I     = 8'h98;

  // Field positions
  localparam int MMU_TEST_BIT   = 3;
  localparam int LOCK_BASE_LSB  = 26;
  localparam int LOCK_VICT_LSB  = 20;
  localparam int LOCK_PRES_BIT  = 0;
  localparam int MVA_TAG_LSB    = 10;
  localparam int PROT_DOM_LSB   = 4;
  localparam int MATCH_PROT_BIT = 24;
  localparam int MATCH_DOM_BIT  = 23;
  localparam int MATCH_MISS_BIT = 22;

  // Reset values and bus answers
  localparam logic [31:0] REG_RST     = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Tag array word layout
  typedef struct packed {
    logic [21:0] tag;
    logic [3:0]  size;
    logic        valid;
    logic        preserve;
    logic [3:0]  sbz;
  } tlbmp_tag_s;

  // Whole state of the port; index 0 is the data side, 1 the instruction side
  typedef struct packed {
    logic [1:0][31:0]                  tb;
    logic [1:0][31:0]                  dom;
    logic [1:0][31:0]                  fs;
    logic [1:0][31:0]                  fa;
    logic [1:0][31:0]                  res;
    logic [1:0][IDX_W-1:0]             vict;
    logic [1:0][IDX_W-1:0]             base;
    logic [1:0][IDX_W-1:0]             pidx;
    logic [1:0]                        pres;
    logic                              mmu_test;
    logic [1:0][TLB_ENTRIES-1:0][31:0] tag;
    logic [1:0][TLB_ENTRIES-1:0][31:0] prot;
    logic [1:0][TLB_ENTRIES-1:0][31:0] ptag;
    logic [7:0]                        awaddr;
    logic                              aw_got;
    logic [31:0]                       wdata;
    logic [3:0]                        wstrb;
    logic                              w_got;
    logic                              bvalid;
    logic [1:0]                        bresp;
    logic                              rvalid;
    logic [31:0]                       rdata;
    logic [1:0]                        rresp;
  } tlbmp_state_s;

endpackage

// File: tlbmp_port.sv
`timescale 1ns/1ps
// Contract
// - Base write updates both sides; base read returns data side.
// - Test ops write each side's base and read the instruction base.
// - Domain write loads both sides; domain read returns data side.
// - Test ops write each side's domain and read the instruction domain.
// - Fault status of either side is readable and writable.
// - Test alias of instruction fault status behaves as the normal one.
// - Fault address of either side is readable and writable.
// - Invalidate ops are write only: both, instruction or data side.
// - Single entry invalidate by modified virtual address per side.
// - Victim, lockdown base and preserve bit readable and writable per side.
// - Tag, protection and physical tag arrays read and written per side.
// - Match returns fault, miss and protection into the side's latch.
// - Array writes may target both buffers in one operation.
// - With test bit set, index advances after tag and protection accesses.
// - With test bit clear, index advances only after protection writes.
// - A match miss never starts a page table walk.
// - Array reads and matches land in 32-bit latches read later.
// - Domain register covers sixteen two-bit domain fields.
// - Every operation is reachable by debug hosts through the same port.
// - Physical tag index is a delayed copy of the tag/protection index.
module tlbmp_port
  import tlbmp_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  tlbmp_state_s s;
  tlbmp_state_s next_s;
  logic         wr_fire;
  logic [31:0]  wd;

  // Byte lane merge for stored registers
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        r[8*b +: 8] = new_v[8*b +: 8];
    return r;
  endfunction

  // Tag bits taking part in a compare for each region size
  function automatic logic [21:0] size_mask(input logic [3:0] size);
    case (size)
      4'h1:    size_mask = 22'h3ffffc;
      4'h3:    size_mask = 22'h3ffff0;
      4'h7:    size_mask = 22'h3fffc0;
      4'hf:    size_mask = 22'h3ffc00;
      default: size_mask = 22'h3fffff;
    endcase
  endfunction

  // True when a valid tag covers the given address
  function automatic logic tag_hit(input logic [31:0] tw, input logic [31:0] modified_virtual_address);
    tlbmp_tag_s t;
    t = tw;
    return t.valid && (((t.tag ^ modified_virtual_address[31:MVA_TAG_LSB]) & size_mask(t.size)) == 22'h0);
  endfunction

  // Match of one side; lowest index wins when entries overlap
  function automatic logic [31:0] match_fn(input logic [TLB_ENTRIES-1:0][31:0] tags,
                                           input logic [TLB_ENTRIES-1:0][31:0] prots,
                                           input logic [31:0] dac,
                                           input logic [31:0] modified_virtual_address);
    logic        hit;
    logic [31:0] pw;
    logic [1:0]  acc;
    logic        dom_f;
    logic        prot_f;
    hit = 1'b0;
    pw  = REG_RST;
    for (int e = TLB_ENTRIES - 1; e >= 0; e--)
      if (tag_hit(tags[e], modified_virtual_address))
      begin
        hit = 1'b1;
        pw  = prots[e];
      end
    acc    = dac[{pw[PROT_DOM_LSB +: 4], 1'b0} +: 2];
    dom_f  = (acc == 2'h0);
    prot_f = (acc == 2'h1) && (pw[3:0] == 4'h1);
    // Miss only reports; nothing here asks for a table walk
    return {7'h00, hit & prot_f, hit & dom_f, ~hit, pw[21:0]};
  endfunction

  // Read data and answer for a bus read
  function automatic logic [33:0] read_fn(input tlbmp_state_s st, input logic [7:0] a);
    logic [31:0] lk;
    lk = REG_RST;
    case (a)
      OFF_TB:        return {RESP_OKAY, st.tb[SIDE_D]};
      OFF_DOM:       return {RESP_OKAY, st.dom[SIDE_D]};
      OFF_FS_D:      return {RESP_OKAY, st.fs[SIDE_D]};
      OFF_FS_I:      return {RESP_OKAY, st.fs[SIDE_I]};
      OFF_FA_D:      return {RESP_OKAY, st.fa[SIDE_D]};
      OFF_FA_I:      return {RESP_OKAY, st.fa[SIDE_I]};
      OFF_LOCK_D,
      OFF_LOCK_I:
      begin
        lk[LOCK_BASE_LSB +: IDX_W] = st.base[a == OFF_LOCK_I];
        lk[LOCK_VICT_LSB +: IDX_W] = st.vict[a == OFF_LOCK_I];
        lk[LOCK_PRES_BIT]          = st.pres[a == OFF_LOCK_I];
        return {RESP_OKAY, lk};
      end
      OFF_T_TB_I:    return {RESP_OKAY, st.tb[SIDE_I]};
      OFF_T_DOM_I:   return {RESP_OKAY, st.dom[SIDE_I]};
      OFF_T_FS_I:    return {RESP_OKAY, st.fs[SIDE_I]};
      OFF_TEST_STAT:
      begin
        lk[MMU_TEST_BIT] = st.mmu_test;
        return {RESP_OKAY, lk};
      end
      OFF_RES_D:     return {RESP_OKAY, st.res[SIDE_D]};
      OFF_RES_I:     return {RESP_OKAY, st.res[SIDE_I]};
      // Write-only operations and holes answer with an error
      default:       return {RESP_SLVERR, REG_RST};
    endcase
  endfunction

  // Channel readies; one write and one read in flight at most
  assign s_axi_awready = !s.aw_got && !s.bvalid;
  assign s_axi_wready  = !s.w_got && !s.bvalid;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign wr_fire       = s.aw_got && s.w_got && !s.bvalid;
  assign wd            = s.wdata;

  // Next state: bus handshakes, then the effect of a completed write
  always_comb
  begin
    logic [1:0] rd_tag;
    logic [1:0] wr_tag;
    logic [1:0] rd_prt;
    logic [1:0] wr_prt;
    logic [1:0] rd_pt;
    logic [1:0] wr_pt;
    logic [1:0] mat;
    logic [1:0] inv_all;
    logic [1:0] inv_one;
    logic       ok;
    logic [33:0] rr;
    rd_tag  = 2'h0;
    wr_tag  = 2'h0;
    rd_prt  = 2'h0;
    wr_prt  = 2'h0;
    rd_pt   = 2'h0;
    wr_pt   = 2'h0;
    mat     = 2'h0;
    inv_all = 2'h0;
    inv_one = 2'h0;
    ok      = 1'b1;
    rr      = {RESP_OKAY, REG_RST};
    next_s  = s;

    // Write address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_s.awaddr = s_axi_awaddr;
      next_s.aw_got = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_s.wdata  = s_axi_wdata;
      next_s.wstrb  = s_axi_wstrb;
      next_s.w_got  = 1'b1;
    end
    if (s.bvalid && s_axi_bready)
      next_s.bvalid = 1'b0;

    // Read answer one cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready)
    begin
      rr            = read_fn(s, s_axi_araddr);
      next_s.rvalid = 1'b1;
      next_s.rdata  = rr[31:0];
      next_s.rresp  = rr[33:32];
    end
    else if (s.rvalid && s_axi_rready)
      next_s.rvalid = 1'b0;

    // Any bus master, a debug host included, drives the same decode
    if (wr_fire)
    begin
      case (s.awaddr)
        OFF_TB:
        begin
          next_s.tb[SIDE_D] = merge(s.tb[SIDE_D], wd, s.wstrb);
          next_s.tb[SIDE_I] = merge(s.tb[SIDE_I], wd, s.wstrb);
        end
        OFF_DOM:
        begin
          next_s.dom[SIDE_D] = merge(s.dom[SIDE_D], wd, s.wstrb);
          next_s.dom[SIDE_I] = merge(s.dom[SIDE_I], wd, s.wstrb);
        end
        OFF_FS_D:      next_s.fs[SIDE_D]  = merge(s.fs[SIDE_D], wd, s.wstrb);
        OFF_FS_I,
        OFF_T_FS_I:    next_s.fs[SIDE_I]  = merge(s.fs[SIDE_I], wd, s.wstrb);
        OFF_FA_D:      next_s.fa[SIDE_D]  = merge(s.fa[SIDE_D], wd, s.wstrb);
        OFF_FA_I:      next_s.fa[SIDE_I]  = merge(s.fa[SIDE_I], wd, s.wstrb);
        OFF_T_TB_I:    next_s.tb[SIDE_I]  = merge(s.tb[SIDE_I], wd, s.wstrb);
        OFF_T_TB_D:    next_s.tb[SIDE_D]  = merge(s.tb[SIDE_D], wd, s.wstrb);
        OFF_T_DOM_I:   next_s.dom[SIDE_I] = merge(s.dom[SIDE_I], wd, s.wstrb);
        OFF_T_DOM_D:   next_s.dom[SIDE_D] = merge(s.dom[SIDE_D], wd, s.wstrb);
        OFF_TEST_STAT: next_s.mmu_test    = wd[MMU_TEST_BIT];
        OFF_LOCK_D,
        OFF_LOCK_I:
        begin
          next_s.base[s.awaddr == OFF_LOCK_I] = wd[LOCK_BASE_LSB +: IDX_W];
          next_s.vict[s.awaddr == OFF_LOCK_I] = wd[LOCK_VICT_LSB +: IDX_W];
          next_s.pres[s.awaddr == OFF_LOCK_I] = wd[LOCK_PRES_BIT];
        end
        OFF_INV_ALL:   inv_all = 2'h3;
        OFF_INV_I:     inv_all = 2'h2;
        OFF_INV_D:     inv_all = 2'h1;
        OFF_INV_ONE_I: inv_one = 2'h2;
        OFF_INV_ONE_D: inv_one = 2'h1;
        OFF_TAG_RD_D:  rd_tag  = 2'h1;
        OFF_TAG_RD_I:  rd_tag  = 2'h2;
        OFF_TAG_WR_D:  wr_tag  = 2'h1;
        OFF_TAG_WR_I:  wr_tag  = 2'h2;
        OFF_TAG_WR_B:  wr_tag  = 2'h3;
        OFF_PRT_RD_D:  rd_prt  = 2'h1;
        OFF_PRT_RD_I:  rd_prt  = 2'h2;
        OFF_PRT_WR_D:  wr_prt  = 2'h1;
        OFF_PRT_WR_I:  wr_prt  = 2'h2;
        OFF_PRT_WR_B:  wr_prt  = 2'h3;
        OFF_PT_RD_D:   rd_pt   = 2'h1;
        OFF_PT_RD_I:   rd_pt   = 2'h2;
        OFF_PT_WR_D:   wr_pt   = 2'h1;
        OFF_PT_WR_I:   wr_pt   = 2'h2;
        OFF_PT_WR_B:   wr_pt   = 2'h3;
        OFF_MATCH_D:   mat     = 2'h1;
        OFF_MATCH_I:   mat     = 2'h2;
        default:       ok      = 1'b0;
      endcase
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = ok ? RESP_OKAY : RESP_SLVERR;
    end

    // Per-side array effects; both sides share one write data word
    for (int i = 0; i < 2; i++)
    begin
      // Preserved entries survive a whole-buffer invalidate
      for (int e = 0; e < TLB_ENTRIES; e++)
      begin
        if (inv_all[i] && !s.tag[i][e][4])
          next_s.tag[i][e][5] = 1'b0;
        if (inv_one[i] && tag_hit(s.tag[i][e], wd))
          next_s.tag[i][e][5] = 1'b0;
      end
      if (wr_tag[i])
        next_s.tag[i][s.vict[i]] = wd;
      if (wr_prt[i])
        next_s.prot[i][s.vict[i]] = wd;
      if (wr_pt[i])
        next_s.ptag[i][s.pidx[i]] = wd;
      // Result latches change only on their own side's result ops
      if (rd_tag[i])
        next_s.res[i] = s.tag[i][s.vict[i]];
      else if (rd_prt[i])
        next_s.res[i] = s.prot[i][s.vict[i]];
      else if (rd_pt[i])
        next_s.res[i] = s.ptag[i][s.pidx[i]];
      else if (mat[i])
        next_s.res[i] = match_fn(s.tag[i], s.prot[i], s.dom[i], wd);
      // The physical tag index trails the index just used
      if (rd_tag[i] || wr_tag[i] || rd_prt[i] || wr_prt[i])
        next_s.pidx[i] = s.vict[i];
      // Index steps in both buffers; wraps back to the lockdown base
      if (s.mmu_test ? ((|(rd_tag | wr_tag | rd_prt | wr_prt))) : (|wr_prt))
        next_s.vict[i] = (s.vict[i] == IDX_W'(TLB_ENTRIES - 1)) ? s.base[i]
                                                                 : s.vict[i] + IDX_W'(1);
    end
  end

  // State register; arrays clear so no stale entry matches after reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= '0;
    else
      s <= next_s;
  end

  // Valid bits of the data buffer; an all-clear set must make any match a miss
  logic [TLB_ENTRIES-1:0] d_valid;
  for (genvar e = 0; e < TLB_ENTRIES; e++)
  begin
    assign d_valid[e] = s.tag[SIDE_D][e][5];
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  both_base_a: assert property (wr_fire && s.awaddr == OFF_TB && s.wstrb == 4'hf |=>
      s.tb[SIDE_D] == $past(wd) && s.tb[SIDE_I] == $past(wd))
    else $error("base write did not reach both sides");

  base_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_TB
      |=> s_axi_rvalid && s_axi_rdata == $past(s.tb[SIDE_D]))
    else $error("base read did not return data side");

  both_domain_a: assert property (wr_fire && s.awaddr == OFF_DOM && s.wstrb == 4'hf
      |=> s.dom[SIDE_D] == s.dom[SIDE_I])
    else $error("domain write did not reach both sides");

  test_step_a: assert property (s.mmu_test && wr_fire
      && (s.awaddr == OFF_TAG_RD_I || s.awaddr == OFF_TAG_RD_D)
      && s.vict[SIDE_I] != IDX_W'(TLB_ENTRIES - 1)
      && s.vict[SIDE_D] != IDX_W'(TLB_ENTRIES - 1)
      |=> s.vict[SIDE_I] == $past(s.vict[SIDE_I]) + IDX_W'(1)
      && s.vict[SIDE_D] == $past(s.vict[SIDE_D]) + IDX_W'(1))
    else $error("index did not step in test mode");

  no_step_a: assert property (!s.mmu_test && wr_fire && s.awaddr == OFF_TAG_WR_B
      |=> $stable(s.vict))
    else $error("index stepped outside protection write");

  ptag_index_a: assert property (wr_fire && s.awaddr == OFF_PRT_RD_D
      |=> s.pidx[SIDE_D] == $past(s.vict[SIDE_D]))
    else $error("physical tag index not copied");

  latch_hold_a: assert property (!(wr_fire && s.awaddr >= OFF_TAG_RD_D
      && s.awaddr <= OFF_MATCH_I) |=> $stable(s.res))
    else $error("result latch changed without an operation");

  miss_flag_a: assert property (wr_fire && s.awaddr == OFF_MATCH_D && d_valid == '0
      |=> s.res[SIDE_D][MATCH_MISS_BIT] && s.res[SIDE_D][21:0] == 22'h0)
    else $error("empty buffer match did not report miss");

  resp_order_a: assert property ($rose(s_axi_bvalid) |-> $past(s.aw_got && s.w_got))
    else $error("write answered before address and data");

endmodule
